/* File: hw/cid_id_if.sv */
// Carrier between the identity word builder and the register bank.
// Assumes both ends sit in the same clock domain; all signals are static levels.
`timescale 1ns/100ps
interface cid_id_if;
   import cid_pkg::*;

   logic [CID_DATA_W-1:0] id_word;      // Assembled identification word
   logic [CID_DATA_W-1:0] ext_word;     // Extension word, zero when absent
   logic nvp_ok;                        // First size code not reserved
   logic nvp2_ok;                       // Second size code not reserved
   logic sram_ok;                       // SRAM size code not reserved
   logic type_ok;                       // Memory type code not reserved

   // Builder side drives every field
   modport producer (
      output id_word,
      output ext_word,
      output nvp_ok,
      output nvp2_ok,
      output sram_ok,
      output type_ok
   );

   // Register bank only reads them
   modport consumer (
      input id_word,
      input ext_word,
      input nvp_ok,
      input nvp2_ok,
      input sram_ok,
      input type_ok
   );
endinterface

/* File: hw/cid_id_word.sv */
// Builds the fixed identification and extension words from strap parameters.
// Assumes the parameters are constant; the output is pure combinational decode.
`timescale 1ns/100ps
module cid_id_word
   import cid_pkg::*;
#(
   parameter logic [CID_VER_W-1:0] P_VERSION = 5'h01,       // Arbitrary value
   parameter logic [CID_CORE_W-1:0] P_CORE = 3'h7,          // Arbitrary value
   parameter logic [CID_ARCHITECTURE_CODE_W-1:0] P_ARCHITECTURE_CODE = 8'hA5,         // Arbitrary value
   parameter logic [CID_SRAM_W-1:0] P_SRAM = 4'hB,
   parameter logic [CID_NVP_W-1:0] P_NVP = 4'h9,
   parameter logic [CID_NVP2_W-1:0] P_NVP2 = 4'h0,
   parameter logic [CID_TYPE_W-1:0] P_TYPE = 3'h2,
   parameter logic P_EXT = 1'b0,
   parameter logic [CID_DATA_W-1:0] P_EXT_VALUE = 32'h0000_0000
) (
   cid_id_if.producer id
);

   // ****************************************************************
   // Code checks
   // ****************************************************************

   // Both program memory size fields share one legal code set
   function automatic logic nvp_legal(input logic [3:0] code);
      logic ok;
      ok = 1'b0;
      case (code)
         CID_NVP_NONE, CID_NVP_8K, CID_NVP_16K, CID_NVP_32K, CID_NVP_64K,
         CID_NVP_128K, CID_NVP_256K, CID_NVP_512K, CID_NVP_1024K,
         CID_NVP_2048K: begin
            ok = 1'b1;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   // Only the all-zero SRAM code is reserved
   function automatic logic sram_legal(input logic [3:0] code);
      return code != 4'h0;
   endfunction

   // Five memory type codes are defined
   function automatic logic type_legal(input logic [2:0] code);
      logic ok;
      ok = 1'b0;
      case (code)
         CID_TYPE_ROM, CID_TYPE_ROMLESS, CID_TYPE_EFLASH, CID_TYPE_ROM_FLASH,
         CID_TYPE_SRAM_EMU: begin
            ok = 1'b1;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   // ****************************************************************
   // Word assembly
   // ****************************************************************

   // Place every field at its position in the identification word
   always_comb begin
      id.id_word = CID_ZERO;
      id.id_word[CID_EXT_BIT] = P_EXT;
      id.id_word[CID_TYPE_LSB +: CID_TYPE_W] = P_TYPE;
      id.id_word[CID_ARCHITECTURE_CODE_LSB +: CID_ARCHITECTURE_CODE_W] = P_ARCHITECTURE_CODE;
      id.id_word[CID_SRAM_LSB +: CID_SRAM_W] = P_SRAM;
      id.id_word[CID_NVP2_LSB +: CID_NVP2_W] = P_NVP2;
      id.id_word[CID_NVP_LSB +: CID_NVP_W] = P_NVP;
      id.id_word[CID_CORE_LSB +: CID_CORE_W] = P_CORE;
      id.id_word[CID_VER_LSB +: CID_VER_W] = P_VERSION;
   end

   // Extension word is forced to zero when no extension is declared
   assign id.ext_word = P_EXT ? P_EXT_VALUE : CID_ZERO;

   // Legality flags for the strap values
   assign id.nvp_ok = nvp_legal(P_NVP);
   assign id.nvp2_ok = nvp_legal(P_NVP2);
   assign id.sram_ok = sram_legal(P_SRAM);
   assign id.type_ok = type_legal(P_TYPE);

endmodule

/* File: hw/cid_pkg.sv */
// Constants, field layout and code enumerations for the chip identity block.
// Assumes a word-aligned byte-addressed register port driven from the system clock.
package cid_pkg;

   // ****************************************************************
   // Register port geometry
   // ****************************************************************
   localparam int CID_ADDR_W = 8;                       // Byte address width
   localparam int CID_DATA_W = 32;                      // Register data width

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [CID_ADDR_W-1:0] CID_OFF_ID = 8'h00;     // chip_identification
   localparam logic [CID_ADDR_W-1:0] CID_OFF_EXT = 8'h04;    // chip_identification_extension
   localparam logic [CID_ADDR_W-1:0] CID_OFF_TAP = 8'h08;    // tap_reset_override
   localparam logic [CID_ADDR_W-1:0] CID_OFF_CHK = 8'h0C;    // identity_check status

   // ****************************************************************
   // Identification word field layout
   // ****************************************************************
   localparam int CID_EXT_BIT = 31;                     // extension_present_flag
   localparam int CID_TYPE_LSB = 28;                    // program_memory_type
   localparam int CID_TYPE_W = 3;
   localparam int CID_ARCHITECTURE_CODE_LSB = 20;                    // architecture_code
   localparam int CID_ARCHITECTURE_CODE_W = 8;
   localparam int CID_SRAM_LSB = 16;                    // sram_size_code
   localparam int CID_SRAM_W = 4;
   localparam int CID_NVP2_LSB = 12;                    // second_program_memory_size_code
   localparam int CID_NVP2_W = 4;
   localparam int CID_NVP_LSB = 8;                      // program_memory_size_code
   localparam int CID_NVP_W = 4;
   localparam int CID_CORE_LSB = 5;                     // embedded_core_code
   localparam int CID_CORE_W = 3;
   localparam int CID_VER_LSB = 0;                      // version
   localparam int CID_VER_W = 5;

   // ****************************************************************
   // Override and check register layout
   // ****************************************************************
   localparam int CID_TAP_BIT = 0;                      // force_tap_reset_low
   localparam logic CID_TAP_RST = 1'b0;                 // Reset value of the force bit
   localparam int CID_CHK_NVP_BIT = 0;                  // First size code is legal
   localparam int CID_CHK_NVP2_BIT = 1;                 // Second size code is legal
   localparam int CID_CHK_SRAM_BIT = 2;                 // SRAM size code is legal
   localparam int CID_CHK_TYPE_BIT = 3;                 // Memory type code is legal
   localparam int CID_CHK_TAP_BIT = 4;                  // Present TAP reset line level
   localparam logic [CID_DATA_W-1:0] CID_ZERO = 32'h0000_0000;

   // ****************************************************************
   // Program memory size codes
   // ****************************************************************
   typedef enum logic [3:0] {
      CID_NVP_NONE  = 4'h0,
      CID_NVP_8K    = 4'h1,
      CID_NVP_16K   = 4'h2,
      CID_NVP_32K   = 4'h3,
      CID_NVP_64K   = 4'h5,
      CID_NVP_128K  = 4'h7,
      CID_NVP_256K  = 4'h9,
      CID_NVP_512K  = 4'hA,
      CID_NVP_1024K = 4'hC,
      CID_NVP_2048K = 4'hE
   } cid_nvp_size_e;

   // ****************************************************************
   // SRAM size codes (zero is reserved)
   // ****************************************************************
   typedef enum logic [3:0] {
      CID_SRAM_1K   = 4'h1,
      CID_SRAM_2K   = 4'h2,
      CID_SRAM_6K   = 4'h3,
      CID_SRAM_112K = 4'h4,
      CID_SRAM_4K   = 4'h5,
      CID_SRAM_80K  = 4'h6,
      CID_SRAM_160K = 4'h7,
      CID_SRAM_8K   = 4'h8,
      CID_SRAM_16K  = 4'h9,
      CID_SRAM_32K  = 4'hA,
      CID_SRAM_64K  = 4'hB,
      CID_SRAM_128K = 4'hC,
      CID_SRAM_256K = 4'hD,
      CID_SRAM_96K  = 4'hE,
      CID_SRAM_512K = 4'hF
   } cid_sram_size_e;

   // ****************************************************************
   // Program memory type codes
   // ****************************************************************
   typedef enum logic [2:0] {
      CID_TYPE_ROM       = 3'h0,
      CID_TYPE_ROMLESS   = 3'h1,
      CID_TYPE_EFLASH    = 3'h2,
      CID_TYPE_ROM_FLASH = 3'h3,
      CID_TYPE_SRAM_EMU  = 3'h4
   } cid_mem_type_e;

endpackage

/* File: hw/cid_regs.sv */
// Register bank with the chip identification words and the TAP reset override.
// Assumes a one-cycle strobe register port on i_clk and an external power-on
// reset level that is asynchronous to i_clk.
`timescale 1ns/100ps

module cid_regs
   import cid_pkg::*;
#(
   parameter logic [CID_VER_W-1:0] P_VERSION = 5'h01,       // Arbitrary value
   parameter logic [CID_CORE_W-1:0] P_CORE = 3'h7,          // Arbitrary value
   parameter logic [CID_ARCHITECTURE_CODE_W-1:0] P_ARCHITECTURE_CODE = 8'hA5,         // Arbitrary value
   parameter logic [CID_SRAM_W-1:0] P_SRAM = 4'hB,          // SRAM size strap
   parameter logic [CID_NVP_W-1:0] P_NVP = 4'h9,            // First size strap
   parameter logic [CID_NVP2_W-1:0] P_NVP2 = 4'h0,          // Second size strap
   parameter logic [CID_TYPE_W-1:0] P_TYPE = 3'h2,          // Memory type strap
   parameter logic P_EXT = 1'b0,                            // Extension present
   parameter logic [CID_DATA_W-1:0] P_EXT_VALUE = 32'h0000_0000  // Extension value
) (
   input wire logic i_clk,                        // System clock
   input wire logic i_rst_n,                      // Synchronous reset, active low
   input wire logic [CID_ADDR_W-1:0] i_addr,      // Byte address
   input wire logic [CID_DATA_W-1:0] i_wdata,     // Write data
   input wire logic i_wr,                         // Write strobe
   input wire logic i_rd,                         // Read strobe
   output logic [CID_DATA_W-1:0] o_rdata,         // Read data, cycle after strobe
   input wire logic i_por_n,                      // Power-on reset level, active low
   output logic o_tap_reset_n                     // TAP controller reset, active low
);

   // ****************************************************************
   // Internal state
   // ****************************************************************
   cid_id_if id ();                    // Fixed words from the builder
   logic force_tap_reset_low;          // Software override bit
   logic por_meta;                     // First synchroniser stage
   logic por_sync;                     // Second synchroniser stage
   logic [CID_DATA_W-1:0] next_rdata;  // Read mux result
   logic [CID_DATA_W-1:0] chk_word;    // Check register contents

   // ****************************************************************
   // Identity word builder
   // ****************************************************************
   cid_id_word #(
      .P_VERSION(P_VERSION),
      .P_CORE(P_CORE),
      .P_ARCHITECTURE_CODE(P_ARCHITECTURE_CODE),
      .P_SRAM(P_SRAM),
      .P_NVP(P_NVP),
      .P_NVP2(P_NVP2),
      .P_TYPE(P_TYPE),
      .P_EXT(P_EXT),
      .P_EXT_VALUE(P_EXT_VALUE)
   ) u_id_word (
      .id(id)
   );

   // ****************************************************************
   // Override register
   // ****************************************************************

   // Only bit 0 is stored; writes to the upper bits fall away
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         force_tap_reset_low <= CID_TAP_RST;
      end else if (i_wr && (i_addr == CID_OFF_TAP)) begin
         force_tap_reset_low <= i_wdata[CID_TAP_BIT];
      end
   end

   // ****************************************************************
   // Power-on reset synchroniser
   // ****************************************************************

   // Two stages before anything reads the power-on level
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         por_meta <= 1'b0;
         por_sync <= 1'b0;
      end else begin
         por_meta <= i_por_n;
         por_sync <= por_meta;
      end
   end

   // ****************************************************************
   // TAP reset output
   // ****************************************************************

   // Held low while forced or in reset, else follows power-on reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_tap_reset_n <= 1'b0;
      end else if (force_tap_reset_low) begin
         o_tap_reset_n <= 1'b0;
      end else begin
         o_tap_reset_n <= por_sync;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************

   // Check register: strap legality and the live TAP reset level
   always_comb begin
      chk_word = CID_ZERO;
      chk_word[CID_CHK_NVP_BIT] = id.nvp_ok;
      chk_word[CID_CHK_NVP2_BIT] = id.nvp2_ok;
      chk_word[CID_CHK_SRAM_BIT] = id.sram_ok;
      chk_word[CID_CHK_TYPE_BIT] = id.type_ok;
      chk_word[CID_CHK_TAP_BIT] = o_tap_reset_n;
   end

   // Address decode; unmapped or unaligned addresses read zero
   always_comb begin
      next_rdata = CID_ZERO;
      if (i_rd) begin
         case (i_addr)
            CID_OFF_ID: begin
               next_rdata = id.id_word;
            end
            CID_OFF_EXT: begin
               next_rdata = id.ext_word;
            end
            CID_OFF_TAP: begin
               next_rdata[CID_TAP_BIT] = force_tap_reset_low;
            end
            CID_OFF_CHK: begin
               next_rdata = chk_word;
            end
            default: begin
               next_rdata = CID_ZERO;
            end
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= CID_ZERO;
      end else begin
         o_rdata <= next_rdata;
      end
   end

endmodule

/* File: test/cid_regs_assertions.sv */
// Port checker for the chip identity register bank.
// Assumes binding into every cid_regs instance with its own straps.
`timescale 1ns/100ps
module cid_regs_assertions
   import cid_pkg::*;
#(
   parameter logic [CID_VER_W-1:0] P_VERSION = 5'h01,       // Arbitrary value
   parameter logic [CID_CORE_W-1:0] P_CORE = 3'h7,          // Arbitrary value
   parameter logic [CID_ARCHITECTURE_CODE_W-1:0] P_ARCHITECTURE_CODE = 8'hA5,         // Arbitrary value
   parameter logic [CID_SRAM_W-1:0] P_SRAM = 4'hB,
   parameter logic [CID_NVP_W-1:0] P_NVP = 4'h9,
   parameter logic [CID_NVP2_W-1:0] P_NVP2 = 4'h0,
   parameter logic [CID_TYPE_W-1:0] P_TYPE = 3'h2,
   parameter logic P_EXT = 1'b0,
   parameter logic [CID_DATA_W-1:0] P_EXT_VALUE = 32'h0000_0000
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [CID_ADDR_W-1:0] i_addr,
   input wire logic [CID_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [CID_DATA_W-1:0] o_rdata,
   input wire logic i_por_n,
   input wire logic o_tap_reset_n
);
   // ****
   // Helper state
   // ****
   // Identification word as the straps should assemble it
   localparam logic [CID_DATA_W-1:0] ID_WORD =
      {P_EXT, P_TYPE, P_ARCHITECTURE_CODE, P_SRAM, P_NVP2, P_NVP, P_CORE, P_VERSION};
   logic force_q; // Mirror of the force bit

   // Follows software writes to the override register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         force_q <= 1'b0;
      end else if (i_wr && i_addr == CID_OFF_TAP) begin
         force_q <= i_wdata[CID_TAP_BIT];
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // ****
   // Properties
   // ****
   property p_id_word;
      i_rd && i_addr == CID_OFF_ID |=> o_rdata == ID_WORD;
   endproperty
   a_id_word: assert property (p_id_word) else $error("id word wrong");
   property p_ext_flag;
      i_rd && i_addr == CID_OFF_ID |=> o_rdata[CID_EXT_BIT] == P_EXT;
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("ext flag wrong");
   property p_ext_word;
      i_rd && i_addr == CID_OFF_EXT |=> o_rdata == (P_EXT ? P_EXT_VALUE : CID_ZERO);
   endproperty
   a_ext_word: assert property (p_ext_word) else $error("ext word wrong");
   property p_tap_read;
      i_rd && i_addr == CID_OFF_TAP |=> o_rdata == {31'h0, $past(force_q)};
   endproperty
   a_tap_read: assert property (p_tap_read) else $error("override read wrong");
   property p_force_low;
      i_wr && i_addr == CID_OFF_TAP && i_wdata[0] |=> ##1 !o_tap_reset_n;
   endproperty
   a_force_low: assert property (p_force_low) else $error("force not low");
   property p_por_low;
      !i_por_n [*3] |=> !o_tap_reset_n;
   endproperty
   a_por_low: assert property (p_por_low) else $error("por low lost");
   property p_por_pass;
      (i_rst_n && i_por_n) [*3] ##0 !force_q |=> o_tap_reset_n;
   endproperty
   a_por_pass: assert property (p_por_pass) else $error("por high lost");
   property p_rst_clear;
      $rose(i_rst_n) |-> !o_tap_reset_n && o_rdata == CID_ZERO;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset state wrong");
endmodule

bind cid_regs cid_regs_assertions #(.P_VERSION(P_VERSION), .P_CORE(P_CORE),
   .P_ARCHITECTURE_CODE(P_ARCHITECTURE_CODE), .P_SRAM(P_SRAM), .P_NVP(P_NVP), .P_NVP2(P_NVP2), .P_TYPE(P_TYPE),
   .P_EXT(P_EXT), .P_EXT_VALUE(P_EXT_VALUE)) u_cid_regs_assertions (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_por_n(i_por_n), .o_tap_reset_n(o_tap_reset_n));

/* File: test/cid_regs_bench.sv */
// Self-checking bench for the chip identity register bank.
// Assumes cid_pkg and the bound checker are compiled first.
`timescale 1ns/100ps
module cid_regs_bench
   import cid_pkg::*;
;
   // ****
   // Stimulus and observed signals
   // ****
   logic clk = 1'b0; // System clock
   logic rst_n = 1'b0; // Reset, active low
   logic [CID_ADDR_W-1:0] addr = 8'h00; // Register address
   logic [CID_DATA_W-1:0] wdata = 32'h0000_0000; // Write data
   logic wr = 1'b0; // Write strobe
   logic rd = 1'b0; // Read strobe
   logic por_n = 1'b0; // Power-on reset, active low
   logic [CID_DATA_W-1:0] rdata_a; // Read data, no extension
   logic [CID_DATA_W-1:0] rdata_b; // Read data, extension present
   logic tap_a_n; // TAP reset of first instance
   logic tap_b_n; // TAP reset of second instance
   int num_errors = 0;
   int checks_done = 0;
   // Expected words; identity straps keep their arbitrary default values, except version 5'h1F on the second
   localparam logic [31:0] ID_A = 32'h2A5B_09E1;
   localparam logic [31:0] ID_B = 32'hBA5B_D9FF;
   localparam logic [31:0] EXT_B = 32'h8765_4321;
   // Check register: all straps legal on the first, second size code reserved on the other
   localparam logic [31:0] CHK_A = 32'h0000_000F;
   localparam logic [31:0] CHK_B = 32'h0000_000D;
   localparam logic [31:0] CHK_TAP = 32'h0000_0010; // TAP reset line level bit

   // Clock of 8 ns period
   always #4 clk = ~clk;

   // Default straps: no extension, embedded flash, one size field
   cid_regs u_cid_regs (.i_clk(clk), .i_rst_n(rst_n),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata_a),
      .i_por_n(por_n), .o_tap_reset_n(tap_a_n));
   // Extension present, ROM plus flash, reserved second size code
   cid_regs #(.P_VERSION(5'h1F), .P_NVP2(4'hD), .P_TYPE(3'h3), .P_EXT(1'b1),
      .P_EXT_VALUE(EXT_B)) u_cid_regs_ext (.i_clk(clk), .i_rst_n(rst_n),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata_b),
      .i_por_n(por_n), .o_tap_reset_n(tap_b_n));

   // ****
   // Tasks
   // ****
   // Compares one word and counts the result
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle write strobe, then one idle edge so strobes never clash
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // One-cycle read strobe; data checked mid-way through the cycle after it
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] ea, input logic [31:0] eb);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("rdata_a", ea, rdata_a);
      chk("rdata_b", eb, rdata_b);
      @(posedge clk);
   endtask
   // Waits n edges, checks both TAP reset levels mid-cycle, ends on the next edge
   task automatic tap(input int n, input logic e);
      repeat (n) @(posedge clk);
      @(negedge clk);
      chk("tap_a_n", {31'h0, e}, {31'h0, tap_a_n});
      chk("tap_b_n", {31'h0, e}, {31'h0, tap_b_n});
      @(posedge clk);
   endtask
   // Prints the counts and the verdict
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs under 100 cycles, so 2000 means a hang
   initial begin
      repeat (2000) @(posedge clk);
      num_errors++;
      test_done();
   end

   // ****
   // Test sequence
   // ****
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      tap(1, 1'b0);
      rd_reg(CID_OFF_TAP, 32'h0, 32'h0);
      por_n <= 1'b1;
      tap(2, 1'b0);
      tap(0, 1'b1);
      rd_reg(CID_OFF_ID, ID_A, ID_B);
      rd_reg(CID_OFF_EXT, 32'h0, EXT_B);
      // Strap legality flags, TAP line high
      rd_reg(CID_OFF_CHK, CHK_A | CHK_TAP, CHK_B | CHK_TAP);
      // Writes to read-only words are ignored
      wr_reg(CID_OFF_ID, 32'hFFFF_FFFF);
      wr_reg(CID_OFF_EXT, 32'hFFFF_FFFF);
      rd_reg(CID_OFF_ID, ID_A, ID_B);
      rd_reg(CID_OFF_EXT, 32'h0, EXT_B);
      // Force bit set with all upper bits, read back at once
      wr_reg(CID_OFF_TAP, 32'hFFFF_FFFF);
      rd_reg(CID_OFF_TAP, 32'h1, 32'h1);
      tap(1, 1'b0);
      rd_reg(CID_OFF_CHK, CHK_A, CHK_B);
      wr_reg(CID_OFF_TAP, 32'hFFFF_FFFE);
      rd_reg(CID_OFF_TAP, 32'h0, 32'h0);
      tap(1, 1'b1);
      // Power-on reset passes through while not forced
      por_n <= 1'b0;
      tap(2, 1'b1);
      tap(0, 1'b0);
      // Forced low holds whatever the power-on level does
      wr_reg(CID_OFF_TAP, 32'h1);
      por_n <= 1'b1;
      tap(5, 1'b0);
      // Reset in mid-run clears the force bit
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(CID_OFF_TAP, 32'h0, 32'h0);
      tap(0, 1'b0);
      tap(0, 1'b1);
      test_done();
   end
endmodule
